// file: logic/fsc_pkg.sv
// Shared constants, types and reset values of the forced stop controller.
package fsc_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 20;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int TRQ_W = 10;
   localparam int TIME_W = 14;
   localparam int SPD_W = 16;
   localparam int PIN_N = 8;
   localparam int ALLOC_W = 4;
   localparam int METH_W = 3;
   localparam int SOFF_W = 2;
   localparam int ERR_W = 24;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_ESTOP_TRQ = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DECEL_TIME = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_MAX_TRQ = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_SERVO_ON_BIT = 0;
   localparam int CTRL_TORQUE_BIT = 1;
   localparam int CTRL_RESTART_BIT = 2;
   localparam int CFG_ALLOC_LSB = 0;
   localparam int CFG_METHOD_LSB = 4;
   localparam int CFG_SOFF_LSB = 8;
   localparam int CFG_PEND_LSB = 12;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_DECEL_BIT = 1;
   localparam int ST_STOPPED_BIT = 2;
   localparam int ST_METHOD_LSB = 4;
   localparam int ST_INPUT_BIT = 8;
   localparam int ST_ALLOC_BIT = 9;
   // ---------------------------------------------------------------
   // Limits and reset values
   // ---------------------------------------------------------------
   localparam logic [TRQ_W-1:0] TRQ_LIMIT = 10'h320;
   localparam logic [TRQ_W-1:0] TRQ_RST = TRQ_LIMIT;
   localparam logic [TRQ_W-1:0] MAX_TRQ_RST = 10'h12c;
   localparam logic [TIME_W-1:0] DECEL_LIMIT = 14'h2710;
   localparam logic [TIME_W-1:0] DECEL_RST = 14'h0000;
   localparam logic [SPD_W-1:0] MAX_SPEED_DEF = 16'h1770;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [METH_W-1:0] {
      FSM_DB_COAST, FSM_TRQ_SOFF, FSM_TRQ_COAST, FSM_TIME_SOFF, FSM_TIME_COAST
   } fsc_method_e;
   typedef enum logic [SOFF_W-1:0] {
      SOFF_DB, SOFF_COAST, SOFF_TRQ_LOCK
   } fsc_soff_e;
   typedef enum logic [2:0] {
      ST_BASE_BLOCK, ST_RUN, ST_DECEL_TRQ, ST_DECEL_TIME, ST_STOPPED
   } fsc_stop_e;
   typedef struct packed {
      logic brake_short;
      logic coast;
      logic servo_lock;
      logic speed_ovr;
      logic [SPD_W-1:0] speed_ref;
      logic trq_lim_en;
      logic [TRQ_W-1:0] trq_lim;
   } fsc_drive_s;
   typedef struct packed {
      fsc_stop_e st;
      logic servo_on;
      logic torque_mode;
      logic [ALLOC_W-1:0] alloc;
      fsc_method_e meth_pend;
      fsc_method_e meth_act;
      fsc_method_e meth_run;
      fsc_soff_e soff;
      logic [TRQ_W-1:0] estop_trq;
      logic [TRQ_W-1:0] max_trq;
      logic [TIME_W-1:0] decel;
      logic ramp_load;
      logic ack;
      logic [DATA_W-1:0] rdata;
      fsc_drive_s drv;
   } fsc_core_s;
   typedef struct packed {
      logic [SPD_W-1:0] speed;
      logic [ERR_W-1:0] err;
   } fsc_ramp_s;
   typedef struct packed {
      logic [TICK_W-1:0] cnt;
      logic tick;
   } fsc_tick_s;
   // Power-up state: servo-off method forced to torque stop and lock.
   localparam fsc_core_s CORE_RST = '{st: ST_BASE_BLOCK,
      meth_pend: FSM_TRQ_SOFF, meth_act: FSM_TRQ_SOFF,
      meth_run: FSM_TRQ_SOFF, soff: SOFF_TRQ_LOCK, estop_trq: TRQ_RST,
      max_trq: MAX_TRQ_RST, decel: DECEL_RST, default: '0}; // R9
endpackage

// file: logic/fsc_tick.sv
// Millisecond tick generator for the forced stop controller.
`timescale 1ns/1ps
module fsc_tick import fsc_pkg::*; #(
   parameter int CYCLES = MS_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic rst,
   output logic tick
);
   fsc_tick_s cur_reg;
   fsc_tick_s cur_next;

   // Count clock cycles and pulse once per millisecond.
   always_comb begin
      cur_next = cur_reg;
      cur_next.tick = (cur_reg.cnt == TICK_W'(CYCLES - 1));
      cur_next.cnt = cur_next.tick ? '0 : cur_reg.cnt + TICK_W'(1);
   end

   // State register.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign tick = cur_reg.tick;
endmodule

// file: logic/fsc_ramp.sv
// Linear speed ramp to zero with a slope set by full-speed decel time.
`timescale 1ns/1ps
module fsc_ramp import fsc_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic tick,
   input wire logic [SPD_W-1:0] start_speed,
   input wire logic [SPD_W-1:0] max_speed,
   input wire logic [TIME_W-1:0] decel_time,
   output logic [SPD_W-1:0] speed,
   output logic done
);
   fsc_ramp_s cur_reg;
   fsc_ramp_s cur_next;

   // Each millisecond adds max speed to an error sum; each whole decel
   // time in the sum takes one speed step, so full speed ends on time.
   always_comb begin
      cur_next = cur_reg;
      if (load) begin
         cur_next.speed = start_speed;
         cur_next.err = '0;
      end else if (decel_time == '0) begin
         cur_next.speed = '0; // R11
      end else begin
         if (tick) begin
            cur_next.err = cur_reg.err + ERR_W'(max_speed); // R12
         end
         if (cur_reg.err >= ERR_W'(decel_time) && cur_reg.speed != '0) begin
            cur_next.err = cur_next.err - ERR_W'(decel_time); // R12
            cur_next.speed = cur_reg.speed - SPD_W'(1);
         end
      end
   end

   // State register.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign speed = cur_reg.speed;
   assign done = (cur_reg.speed == '0);
endmodule

// file: logic/fsc_top.sv
// Forced stop controller with an Avalon-MM register slave.
//
// Summary of operation
// R1 - Input closed lets the drive run; input open stops the motor.
// R2 - An unallocated forced stop input has no effect at all.
// R3 - Method zero brakes by short circuit or coasts, per servo-off method.
// R4 - Methods one and two brake at emergency torque, then servo-off or coast.
// R5 - Methods three and four ramp down in time, then servo-off or coast.
// R6 - Torque control never decelerates; it brakes or coasts instead.
// R7 - Emergency torque is 0 to 800 percent, default 800, live.
// R8 - Applied stop torque never exceeds the motor maximum torque.
// R9 - Power-up sets servo-off method to torque stop then servo lock.
// R10 - Stop decel time is 0 to 10000 ms, default 0, live.
// R11 - Zero decel time commands zero speed at once.
// R12 - Ramp slope takes maximum speed to zero in the set time.
// R13 - A tripped stop holds while servo-on stays asserted.
// R14 - Host clears a stop with servo off, then servo on.
// R15 - A stop in effect drives the forced stop display.
// R16 - A new method only takes effect at restart.
// R17 - Status shows stop active until servo off then on; here it clears one cycle after servo off.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module fsc_top import fsc_pkg::*; #(
   parameter int MS_CYCLES = MS_CYCLES_DEF,
   parameter logic [SPD_W-1:0] MAX_SPEED = MAX_SPEED_DEF
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic [PIN_N-1:0] forced_stop_input_pins,
   input wire logic [SPD_W-1:0] motor_speed,
   output fsc_drive_s drive,
   output logic forced_stop_display,
   output logic forced_stop_active
);
   fsc_core_s cur_reg;
   fsc_core_s cur_next;
   logic ms_tick;
   logic [SPD_W-1:0] ramp_speed;
   logic ramp_done;
   logic closed;
   logic allocated;
   logic active;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Braking by short circuit or coasting, as the servo-off method says.
   function automatic fsc_drive_s db_or_coast(input fsc_soff_e soff);
      fsc_drive_s d;
      d = '0;
      d.coast = (soff == SOFF_COAST);
      d.brake_short = (soff != SOFF_COAST);
      return d;
   endfunction

   // What the drive does once the motor has come to rest.
   function automatic fsc_drive_s post_stop(input fsc_method_e m,
                                            input fsc_soff_e soff);
      fsc_drive_s d;
      d = '0;
      if (m == FSM_TRQ_COAST || m == FSM_TIME_COAST) begin
         d.coast = 1'b1;
      end else if (soff == SOFF_TRQ_LOCK) begin
         d.servo_lock = 1'b1;
      end else begin
         d = db_or_coast(soff);
      end
      return d;
   endfunction

   // Smaller of two torque figures.
   function automatic logic [TRQ_W-1:0] trq_min(input logic [TRQ_W-1:0] a,
                                               input logic [TRQ_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // Clip a written word to the top of its setting range.
   function automatic logic [DATA_W-1:0] clip(input logic [DATA_W-1:0] v,
                                              input logic [DATA_W-1:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   // ---------------------------------------------------------------
   // Input selection
   // ---------------------------------------------------------------

   // Allocation zero or out of range leaves the stop input unused.
   assign allocated = (cur_reg.alloc != '0) &&
                      (cur_reg.alloc <= ALLOC_W'(PIN_N)); // R2
   // Pin numbers start at one; an unused input reads as closed.
   assign closed = !allocated ||
      forced_stop_input_pins[3'(cur_reg.alloc - ALLOC_W'(1))]; // R2
   assign active = (cur_reg.st == ST_DECEL_TRQ) ||
                   (cur_reg.st == ST_DECEL_TIME) ||
                   (cur_reg.st == ST_STOPPED);

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------

   fsc_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .mclk(mclk),
      .rst(rst),
      .tick(ms_tick)
   );

   fsc_ramp u_ramp (
      .mclk(mclk),
      .rst(rst),
      .load(cur_reg.ramp_load),
      .tick(ms_tick),
      .start_speed(motor_speed),
      .max_speed(MAX_SPEED),
      .decel_time(cur_reg.decel),
      .speed(ramp_speed),
      .done(ramp_done)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------

   // Bus slave and stop sequencer in one pass over the state copy.
   always_comb begin
      cur_next = cur_reg;
      cur_next.ramp_load = 1'b0;
      // Every access waits one cycle, then completes.
      cur_next.ack = (read || write) && !cur_reg.ack;
      if (read && !cur_reg.ack) begin
         cur_next.rdata = '0;
         unique case (address)
            OFS_CTRL: begin
               cur_next.rdata[CTRL_SERVO_ON_BIT] = cur_reg.servo_on;
               cur_next.rdata[CTRL_TORQUE_BIT] = cur_reg.torque_mode;
            end
            OFS_CONFIG: begin
               cur_next.rdata[CFG_ALLOC_LSB +: ALLOC_W] = cur_reg.alloc;
               cur_next.rdata[CFG_METHOD_LSB +: METH_W] = cur_reg.meth_act;
               cur_next.rdata[CFG_SOFF_LSB +: SOFF_W] = cur_reg.soff;
               cur_next.rdata[CFG_PEND_LSB +: METH_W] = cur_reg.meth_pend;
            end
            OFS_ESTOP_TRQ: cur_next.rdata[TRQ_W-1:0] = cur_reg.estop_trq;
            OFS_DECEL_TIME: cur_next.rdata[TIME_W-1:0] = cur_reg.decel;
            OFS_MAX_TRQ: cur_next.rdata[TRQ_W-1:0] = cur_reg.max_trq;
            OFS_STATUS: begin
               cur_next.rdata[ST_ACTIVE_BIT] = active; // R17
               cur_next.rdata[ST_DECEL_BIT] = (cur_reg.st == ST_DECEL_TRQ) ||
                                             (cur_reg.st == ST_DECEL_TIME);
               cur_next.rdata[ST_STOPPED_BIT] = (cur_reg.st == ST_STOPPED);
               cur_next.rdata[ST_METHOD_LSB +: METH_W] = cur_reg.meth_act;
               cur_next.rdata[ST_INPUT_BIT] = closed;
               cur_next.rdata[ST_ALLOC_BIT] = allocated;
            end
            default: cur_next.rdata = '0;
         endcase
      end
      if (write && cur_reg.ack) begin
         unique case (address)
            OFS_CTRL: begin
               cur_next.servo_on = writedata[CTRL_SERVO_ON_BIT];
               cur_next.torque_mode = writedata[CTRL_TORQUE_BIT];
               if (writedata[CTRL_RESTART_BIT]) begin
                  cur_next.meth_act = cur_reg.meth_pend; // R16
               end
            end
            OFS_CONFIG: begin
               cur_next.alloc = writedata[CFG_ALLOC_LSB +: ALLOC_W];
               // Codes beyond the list are ignored; the old one stays.
               if (writedata[CFG_METHOD_LSB +: METH_W] <= FSM_TIME_COAST) begin
                  cur_next.meth_pend = fsc_method_e'(
                     writedata[CFG_METHOD_LSB +: METH_W]); // R16
               end
               if (writedata[CFG_SOFF_LSB +: SOFF_W] <= SOFF_TRQ_LOCK) begin
                  cur_next.soff = fsc_soff_e'(
                     writedata[CFG_SOFF_LSB +: SOFF_W]);
               end
            end
            OFS_ESTOP_TRQ: cur_next.estop_trq = TRQ_W'(clip(writedata,
                                                DATA_W'(TRQ_LIMIT))); // R7
            OFS_DECEL_TIME: cur_next.decel = TIME_W'(clip(writedata,
                                             DATA_W'(DECEL_LIMIT))); // R10
            OFS_MAX_TRQ: cur_next.max_trq = writedata[TRQ_W-1:0];
            default: cur_next.max_trq = cur_reg.max_trq;
         endcase
      end
      // Stop sequencer.
      unique case (cur_reg.st)
         ST_BASE_BLOCK: begin
            cur_next.drv = '0;
            if (cur_reg.servo_on) begin
               cur_next.st = ST_RUN;
            end
         end
         ST_RUN: begin
            cur_next.drv = '0;
            if (!closed) begin // R1
               cur_next.meth_run = cur_reg.meth_act;
               if (cur_reg.torque_mode || cur_reg.meth_act == FSM_DB_COAST) begin
                  cur_next.st = ST_STOPPED; // R3 R6
                  cur_next.drv = db_or_coast(cur_reg.soff); // R3 R6
               end else if (cur_reg.meth_act == FSM_TRQ_SOFF ||
                            cur_reg.meth_act == FSM_TRQ_COAST) begin
                  cur_next.st = ST_DECEL_TRQ; // R4
                  cur_next.drv.speed_ovr = 1'b1;
                  cur_next.drv.trq_lim_en = 1'b1;
                  cur_next.drv.trq_lim = trq_min(cur_next.estop_trq,
                                                 cur_next.max_trq); // R8
               end else begin
                  cur_next.st = ST_DECEL_TIME; // R5
                  cur_next.ramp_load = 1'b1;
                  cur_next.drv.speed_ovr = 1'b1;
                  cur_next.drv.speed_ref = motor_speed;
               end
            end
         end
         ST_DECEL_TRQ: begin
            // Torque ceiling follows live setting changes. It is taken
            // from the settings' next values, so a write and the ceiling
            // land on the same edge and never disagree for a cycle.
            cur_next.drv.trq_lim = trq_min(cur_next.estop_trq,
                                           cur_next.max_trq); // R7 R8
            if (motor_speed == '0) begin
               cur_next.st = ST_STOPPED;
               cur_next.drv = post_stop(cur_reg.meth_run, cur_reg.soff); // R4
            end
         end
         ST_DECEL_TIME: begin
            cur_next.drv.speed_ref = ramp_speed; // R12
            // The ramp's done flag is stale until its load has landed.
            if (!cur_reg.ramp_load && ramp_done) begin
               cur_next.st = ST_STOPPED;
               cur_next.drv = post_stop(cur_reg.meth_run, cur_reg.soff); // R5
            end
         end
         ST_STOPPED: cur_next.st = ST_STOPPED; // R13
         default: cur_next.st = ST_BASE_BLOCK;
      endcase
      // Servo off always drops to base block, which also clears a stop.
      if (!cur_reg.servo_on) begin
         cur_next.st = ST_BASE_BLOCK; // R13 R14
         cur_next.drv = '0;
      end
   end

   // ---------------------------------------------------------------
   // State register and outputs
   // ---------------------------------------------------------------

   // State register.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_reg <= CORE_RST;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // Outputs.
   assign readdata = cur_reg.rdata;
   assign waitrequest = (read || write) && !cur_reg.ack;
   assign drive = cur_reg.drv;
   assign forced_stop_display = active; // R15
   assign forced_stop_active = active; // R17

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_trip;
      cur_reg.st == ST_RUN && cur_reg.servo_on && !closed |=> active;
   endproperty
   a_trip: assert property (p_trip) else $error("open input did not trip"); // R1

   property p_unalloc;
      cur_reg.st == ST_RUN && cur_reg.servo_on && cur_reg.alloc == '0
         |=> cur_reg.st == ST_RUN;
   endproperty
   a_unalloc: assert property (p_unalloc) else $error("unallocated trip"); // R2

   property p_torque_mode;
      cur_reg.st == ST_RUN && cur_reg.servo_on && !closed &&
         cur_reg.torque_mode |=> cur_reg.st == ST_STOPPED &&
         (drive.brake_short || drive.coast) && !drive.speed_ovr;
   endproperty
   a_torque_mode: assert property (p_torque_mode) else $error("decel in torque"); // R6

   property p_trq_cap;
      cur_reg.st == ST_DECEL_TRQ |-> drive.trq_lim_en &&
         drive.trq_lim <= cur_reg.max_trq && drive.trq_lim <= cur_reg.estop_trq;
   endproperty
   a_trq_cap: assert property (p_trq_cap) else $error("stop torque too high"); // R8

   property p_ranges;
      cur_reg.estop_trq <= TRQ_LIMIT && cur_reg.decel <= DECEL_LIMIT;
   endproperty
   a_ranges: assert property (p_ranges) else $error("setting out of range"); // R10

   // The ramp takes the start speed on the load edge and clears one
   // edge later, so zero speed shows two cycles after the load flag.
   property p_zero_time;
      cur_reg.ramp_load && cur_reg.decel == '0 && $stable(cur_reg.decel)
         |=> ##1 ramp_speed == '0;
   endproperty
   a_zero_time: assert property (p_zero_time) else $error("no zero speed"); // R11

   property p_hold;
      active && cur_reg.servo_on |=> active;
   endproperty
   a_hold: assert property (p_hold) else $error("stop released early"); // R13

   property p_method_sample;
      !(write && cur_reg.ack && address == OFS_CTRL &&
        writedata[CTRL_RESTART_BIT]) |=> $stable(cur_reg.meth_act);
   endproperty
   a_method_sample: assert property (p_method_sample) else $error("method moved"); // R16

   property p_clear;
      active && !cur_reg.servo_on |=> !active ##1 !active;
   endproperty
   a_clear: assert property (p_clear) else $error("stop not cleared"); // R17

   c_trq_stop: cover property (cur_reg.st == ST_DECEL_TRQ ##[1:50] cur_reg.st
                               == ST_STOPPED);
   c_time_stop: cover property (cur_reg.st == ST_DECEL_TIME ##[1:500]
                                cur_reg.st == ST_STOPPED);
   c_reset_seq: cover property (active ##1 cur_reg.st == ST_BASE_BLOCK
                                ##[1:20] cur_reg.st == ST_RUN);
endmodule

// file: sim/fsc_motor_model.sv
// Model of the stop switch and the motor beyond the controller.
`timescale 1ns/1ps
module fsc_motor_model import fsc_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic open_cmd,
   input wire logic load,
   input wire logic [SPD_W-1:0] load_speed,
   input wire fsc_drive_s drive,
   output logic [PIN_N-1:0] pins,
   output logic [SPD_W-1:0] motor_speed
);
   // The switch opens only pin index 2; every other contact stays closed.
   assign pins = open_cmd ? 8'hfb : 8'hff;
   // The motor follows a ramp, or loses one step a clock while braking or coasting.
   always_ff @(posedge mclk) begin
      if (rst) begin
         motor_speed <= 16'h0000;
      end else if (load) begin
         motor_speed <= load_speed;
      end else if (drive.speed_ovr && !drive.trq_lim_en) begin
         motor_speed <= drive.speed_ref;
      end else if (motor_speed != 16'h0000 && (drive.speed_ovr ||
            drive.coast || drive.brake_short)) begin
         motor_speed <= motor_speed - 16'h0001;
      end
   end
endmodule

// file: sim/forced_stop_controller_tb_top.sv
// Self-checking bench of the forced stop controller.
`timescale 1ns/1ps
module forced_stop_controller_tb_top import fsc_pkg::*;;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [DATA_W-1:0] writedata = 32'h0;
   logic [DATA_W-1:0] readdata;
   logic waitrequest, open_cmd = 1'b0, load = 1'b0, display, active;
   logic [SPD_W-1:0] load_speed = 16'h0000;
   logic [SPD_W-1:0] motor_speed;
   logic [PIN_N-1:0] pins;
   fsc_drive_s drive;
   int mismatches = 0;
   int cmp_count = 0;
   int n;
   logic [2:0] post [5] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b010};
   // ---------------------------------------------------------------
   // Design, partner and clock
   // ---------------------------------------------------------------
   fsc_top #(.MS_CYCLES(20), .MAX_SPEED(16'h0010)) dut (.mclk(mclk),
      .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .forced_stop_input_pins(pins),
      .motor_speed(motor_speed), .drive(drive),
      .forced_stop_display(display), .forced_stop_active(active));
   fsc_motor_model motor (.mclk(mclk), .rst(rst), .open_cmd(open_cmd),
      .load(load), .load_speed(load_speed), .drive(drive), .pins(pins),
      .motor_speed(motor_speed));
   // The clock toggles every half period of 8 ns.
   always #4 mclk = ~mclk;
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      @(posedge mclk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge mclk);
      while (waitrequest !== 1'b0) @(posedge mclk);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [DATA_W-1:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [ADDR_W-1:0] a,
         input logic [31:0] e);
      logic [DATA_W-1:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask
   // Sets the motor speed, opens the contact and checks the trip.
   task automatic trip(input logic [SPD_W-1:0] s);
      @(posedge mclk);
      load <= 1'b1;
      load_speed <= s;
      @(posedge mclk);
      load <= 1'b0;
      open_cmd <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("display active", {display, active}, 2'b11);
   endtask
   // Counts clocks until a post-stop state shows, with a bound.
   task automatic wait_stop(output int c);
      c = 0;
      while ((drive.coast | drive.servo_lock | drive.brake_short) !== 1'b1
            && c < 2000) begin
         @(posedge mclk);
         c++;
      end
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   // The main sequence runs the tests one after another.
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rdc("config", OFS_CONFIG, 32'h1210);
      rdc("estop", OFS_ESTOP_TRQ, 32'h320);
      rdc("decel", OFS_DECEL_TIME, 32'h0);
      rdc("max trq", OFS_MAX_TRQ, 32'h12c);
      rdc("status", OFS_STATUS, 32'h110);
      rdc("unmapped", 5'h18, 32'h0);
      wr(OFS_ESTOP_TRQ, 32'h3ff);
      rdc("estop clip", OFS_ESTOP_TRQ, 32'h320);
      wr(OFS_DECEL_TIME, 32'h3fff);
      rdc("decel clip", OFS_DECEL_TIME, 32'h2710);
      wr(OFS_DECEL_TIME, 32'h0);
      $display("test reset done");
      wr(OFS_CTRL, 32'h1);
      @(posedge mclk);
      open_cmd <= 1'b1;
      repeat (5) @(posedge mclk);
      chk("unallocated", active, 1'b0);
      open_cmd <= 1'b0;
      wr(OFS_CTRL, 32'h0);
      $display("test unallocated done");
      wr(OFS_CONFIG, 32'h213);
      wr(OFS_CTRL, 32'h1);
      trip(16'd500);
      chk("trq ceiling", drive.trq_lim, 10'h12c);
      wr(OFS_ESTOP_TRQ, 32'h64);
      @(posedge mclk);
      #1;
      chk("trq live", drive.trq_lim, 10'h064);
      wait_stop(n);
      chk("lock", drive.servo_lock, 1'b1);
      open_cmd <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("latched", active, 1'b1);
      wr(OFS_CTRL, 32'h0);
      @(posedge mclk);
      #1;
      chk("cleared", active, 1'b0);
      wr(OFS_CTRL, 32'h1);
      @(posedge mclk);
      #1;
      chk("run", {active, drive}, 0);
      wr(OFS_CTRL, 32'h0);
      $display("test latch done");
      for (int m = 0; m < 5; m++) begin
         wr(OFS_CONFIG, 32'h203 | (m << 4));
         rdc("pending", OFS_CONFIG, 32'h203 | ((m == 0 ? 1 : m - 1) << 4)
            | (m << 12));
         wr(OFS_CTRL, 32'h5);
         rdc("active method", OFS_STATUS, 32'h300 | (m << 4));
         trip(16'd40);
         wait_stop(n);
         chk("post stop", {drive.brake_short, drive.coast,
            drive.servo_lock}, post[m]);
         open_cmd <= 1'b0;
         wr(OFS_CTRL, 32'h0);
      end
      $display("test methods done");
      wr(OFS_CONFIG, 32'h213);
      wr(OFS_CTRL, 32'h7);
      trip(16'd40);
      chk("torque mode", {drive.brake_short, drive.speed_ovr}, 2'b10);
      open_cmd <= 1'b0;
      wr(OFS_CTRL, 32'h0);
      $display("test torque mode done");
      wr(OFS_CONFIG, 32'h233);
      wr(OFS_DECEL_TIME, 32'h4);
      wr(OFS_CTRL, 32'h5);
      trip(16'h0010);
      wait_stop(n);
      chk("ramp time", (n >= 60 && n <= 100), 1'b1);
      $display("test ramp done");
      end_sim;
   end
   // A watchdog cuts a hung run short.
   initial begin
      repeat (50000) @(posedge mclk);
      mismatches++;
      end_sim;
   end
endmodule
